// >>> sim/dtc_core_model.sv
/*
  Processor core side: answers a pending timer request by pulsing the
  acknowledge that matches the offered vector. Assumes one clock.
*/
`default_nettype none
module dtc_core_model
  import dtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [3:0] latency,
  input  wire logic       req_valid,
  input  wire logic [7:0] req_vector,
  output logic            ack0,
  output logic            ack1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // A prompt core may pulse again while the cleared request drains; that
  // repeat hits an already clear flag and is harmless.
  always_ff @(posedge clk) begin
    ack0 <= 1'b0;
    ack1 <= 1'b0;
    if (reset || !enable || !req_valid) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt < latency) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      ack0     <= (req_vector == VEC_T0);
      ack1     <= (req_vector == VEC_T1);
      wait_cnt <= 4'h0;
    end
  end
endmodule : dtc_core_model
`default_nettype wire

// >>> sim/dtc_timer_sva.sv
/*
  Concurrent checks on the ports of the dual timer/counter top module.
  Assumes it is bound to dtc_timer_top and runs on its single clock.
*/
`default_nettype none
module dtc_timer_sva
  import dtc_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       VECTOR_ACK0,
  input wire logic       TIMER0_REQ,
  input wire logic       TIMER1_REQ,
  input wire logic       TIMER0_PRIO_HIGH,
  input wire logic       TIMER1_PRIO_HIGH,
  input wire logic       REQ_VALID,
  input wire logic [7:0] REQ_VECTOR
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ie;
  logic [7:0] ip;
  // The enable and priority registers are rebuilt from bus writes.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ie <= 8'h00;
      ip <= 8'h00;
    end else if (WR && ADDR == OFS_INT_ENABLE) begin
      ie <= WDATA & IE_WRITABLE;
    end else if (WR && ADDR == OFS_INT_PRIORITY) begin
      ip <= WDATA & IP_WRITABLE;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_ie_readback: assert property (RD && ADDR == OFS_INT_ENABLE |=> RDATA == ie)
    else $error("enable register reads back wrong");
  chk_prio_level: assert property (TIMER0_PRIO_HIGH == ip[1] && TIMER1_PRIO_HIGH == ip[3])
    else $error("priority outputs disagree with priority register");
  chk_req0_enabled: assert property (TIMER0_REQ |-> $past(ie[7] && ie[1]))
    else $error("timer 0 request without its enables");
  chk_req1_enabled: assert property (TIMER1_REQ |-> $past(ie[7] && ie[3]))
    else $error("timer 1 request without its enables");
  chk_sw_set_req: assert property (WR && ADDR == OFS_CONTROL_FLAGS && WDATA[5]
    ##1 ie[7] && ie[1] |=> TIMER0_REQ)
    else $error("software flag set raised no request");
  chk_ack_clear: assert property (VECTOR_ACK0 && !WR |-> ##2 !TIMER0_REQ)
    else $error("vectoring left timer 0 request pending");
  chk_valid_any: assert property (REQ_VALID == (TIMER0_REQ || TIMER1_REQ))
    else $error("request valid disagrees with requests");
  chk_vector_pick: assert property ($stable({TIMER0_PRIO_HIGH, TIMER1_PRIO_HIGH})
    && TIMER1_REQ && (!TIMER0_REQ || (TIMER1_PRIO_HIGH && !TIMER0_PRIO_HIGH))
    |-> REQ_VECTOR == VEC_T1)
    else $error("wrong vector for timer 1 request");
endmodule : dtc_timer_sva
`default_nettype wire

// >>> sim/tb_top.sv
/*
  Self-checking bench: register port, counting modes, gating, split mode
  and timer interrupts. Assumes the core model answers requests.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic [1:0]  cpin = 2'h3;
  logic [1:0]  gpin = 2'h0;
  logic        core_en = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic        ack0;
  logic        ack1;
  logic [7:0]  rdata;
  logic        t0req;
  logic        t1req;
  logic        rhigh;
  logic        rvalid;
  logic [7:0]  rvec;
  logic        irq;
  logic [15:0] note;
  logic [15:0] notes[$];
  logic [31:0] lfsr = 32'h663346f3;
  int          fails = 0;
  int          checked = 0;
  logic [7:0]  ofs[12] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h8e, 8'ha8,
                           8'hb8, 8'hf0, 8'hf1, 8'h90};
  // Per mode: low, high, falls, expected low, expected high.
  logic [7:0]  tab[3][5] = '{'{8'hff, 8'hff, 8'h01, 8'he0, 8'h00},
                             '{8'hfe, 8'hff, 8'h03, 8'h01, 8'h00},
                             '{8'hff, 8'h80, 8'h02, 8'h81, 8'h80}};
  always #10 clk = ~clk;
  dtc_timer_top dtc_timer_top_inst (
    .CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .TIMER0_COUNT_PIN(cpin[0]), .TIMER1_COUNT_PIN(cpin[1]),
    .TIMER0_GATE_PIN(gpin[0]), .TIMER1_GATE_PIN(gpin[1]), .VECTOR_ACK0(ack0),
    .VECTOR_ACK1(ack1), .TIMER0_REQ(t0req), .TIMER1_REQ(t1req), .TIMER0_PRIO_HIGH(),
    .TIMER1_PRIO_HIGH(), .REQ_VALID(rvalid), .REQ_HIGH(rhigh), .REQ_VECTOR(rvec), .IRQ(irq));
  dtc_core_model dtc_core_model_inst (
    .clk(clk), .reset(reset), .enable(core_en), .latency(lat),
    .req_valid(rvalid), .req_vector(rvec), .ack0(ack0), .ack1(ack1));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // A nonzero tolerance covers free-running prescaler phase.
  task automatic compare(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] tol);
    logic [7:0] d;
    d = got - exp;
    checked++;
    if (((d <= tol) || (8'h00 - d <= tol)) !== 1'b1) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] tol);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    notes.push_back({tol, exp});
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rreg
  task automatic falls(input int t, input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      cpin[t] <= 1'b0;
      repeat (4) @(posedge clk);
      cpin[t] <= 1'b1;
    end
    repeat (6) @(posedge clk);
  endtask : falls
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    rd_q <= rd;
    if (rd_q) begin
      note = notes.pop_front();
      compare(rdata, note[7:0], note[15:8]);
    end
  end
  initial begin
    #(20 * 20000);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    foreach (ofs[i]) rreg(ofs[i], 8'h00, 8'h00);
    wreg(OFS_INT_ENABLE, 8'hff);
    rreg(OFS_INT_ENABLE, IE_WRITABLE, 8'h00);
    wreg(OFS_INT_PRIORITY, 8'hff);
    rreg(OFS_INT_PRIORITY, IP_WRITABLE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      wreg(OFS_MODE_SELECT, lfsr[7:0]);
      rreg(OFS_MODE_SELECT, lfsr[7:0], 8'h00);
    end
    wreg(8'h90, 8'hff);
    rreg(8'h90, 8'h00, 8'h00);
    wreg(OFS_INT_ENABLE, 8'h00);
    wreg(OFS_INT_PRIORITY, 8'h00);
    $display("test registers done");
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 3; m++) begin
        wreg(OFS_MODE_SELECT, 8'(4 + m) << (4 * t));
        wreg(OFS_T0_LOW + 8'(t), tab[m][0]);
        wreg(OFS_T0_HIGH + 8'(t), tab[m][1]);
        wreg(OFS_CONTROL_FLAGS, 8'h10 << (2 * t));
        falls(t, tab[m][2]);
        rreg(OFS_T0_LOW + 8'(t), tab[m][3], 8'h00);
        rreg(OFS_T0_HIGH + 8'(t), tab[m][4], 8'h00);
        rreg(OFS_CONTROL_FLAGS, 8'h30 << (2 * t), 8'h00);
        wreg(OFS_CONTROL_FLAGS, 8'h00);
        falls(t, 1);
        rreg(OFS_T0_LOW + 8'(t), tab[m][3], 8'h00);
      end
    end
    $display("test counter modes done");
    wreg(OFS_MODE_SELECT, 8'h0d);
    wreg(OFS_T0_LOW, 8'h00);
    wreg(OFS_CONTROL_FLAGS, 8'h10);
    falls(0, 2);
    rreg(OFS_T0_LOW, 8'h00, 8'h00);
    gpin[0] <= 1'b1;
    falls(0, 2);
    rreg(OFS_T0_LOW, 8'h02, 8'h00);
    $display("test gating done");
    // Timer 1 first, so timer 0 ends on the fast division that split mode uses.
    for (int f = 0; f < 4; f++) begin
      wreg(OFS_MODE_SELECT, 8'h01 << (4 * ((3 - f) / 2)));
      wreg(OFS_DIVIDER_CTRL, 8'(f % 2) << (3 + (3 - f) / 2));
      wreg(OFS_T0_LOW + 8'((3 - f) / 2), 8'h00);
      wreg(OFS_CONTROL_FLAGS, 8'h10 << (2 * ((3 - f) / 2)));
      repeat ((f % 2) ? 400 : 1200) @(posedge clk);
      wreg(OFS_CONTROL_FLAGS, 8'h00);
      rreg(OFS_T0_LOW + 8'((3 - f) / 2), 8'h64, 8'h02);
    end
    $display("test divided clock done");
    wreg(OFS_MODE_SELECT, 8'h37);
    wreg(OFS_T0_LOW, 8'hff);
    wreg(OFS_T0_HIGH, 8'hfe);
    wreg(OFS_T1_LOW, 8'h55);
    wreg(OFS_CONTROL_FLAGS, 8'h50);
    falls(0, 1);
    rreg(OFS_CONTROL_FLAGS, 8'hf0, 8'h00);
    rreg(OFS_T0_LOW, 8'h00, 8'h00);
    rreg(OFS_T1_LOW, 8'h55, 8'h00);
    wreg(OFS_CONTROL_FLAGS, 8'h00);
    $display("test split mode done");
    wreg(OFS_MODE_SELECT, 8'h00);
    wreg(OFS_INT_ENABLE, 8'h8a);
    wreg(OFS_INT_PRIORITY, 8'h08);
    wreg(OFS_CONTROL_FLAGS, 8'ha0);
    settle(3);
    compare(rvec, VEC_T1, 8'h00);
    compare({7'h00, rhigh}, 8'h01, 8'h00);
    wreg(OFS_INT_PRIORITY, 8'h00);
    settle(3);
    compare(rvec, VEC_T0, 8'h00);
    wreg(OFS_INT_ENABLE, 8'h82);
    settle(3);
    compare({6'h00, t1req, t0req}, 8'h01, 8'h00);
    wreg(OFS_CONTROL_FLAGS, 8'h00);
    settle(3);
    compare({6'h00, t1req, t0req}, 8'h00, 8'h00);
    wreg(OFS_INT_ENABLE, 8'h8a);
    for (int l = 0; l < 2; l++) begin
      core_en <= 1'b0;
      lat     <= l ? 4'h9 : 4'h0;
      wreg(OFS_CONTROL_FLAGS, 8'ha0);
      core_en <= 1'b1;
      settle(30);
      rreg(OFS_CONTROL_FLAGS, 8'h00, 8'h00);
    end
    core_en <= 1'b0;
    $display("test interrupts done");
    rreg(OFS_EVENT_STATUS, 8'h03, 8'h00);
    wreg(OFS_EVENT_MASK, 8'h01);
    wreg(OFS_MODE_SELECT, 8'h06);
    wreg(OFS_T0_LOW, 8'hff);
    wreg(OFS_CONTROL_FLAGS, 8'h10);
    falls(0, 1);
    settle(1);
    compare({7'h00, irq}, 8'h01, 8'h00);
    rreg(OFS_EVENT_STATUS, 8'h01, 8'h00);
    settle(2);
    compare({7'h00, irq}, 8'h00, 8'h00);
    $display("test event status done");
    print_verdict();
  end
endmodule : tb_top
bind dtc_timer_top dtc_timer_sva dtc_timer_sva_inst (.CLK, .RESET, .ADDR, .WDATA, .WR,
  .RD, .RDATA, .VECTOR_ACK0, .TIMER0_REQ, .TIMER1_REQ, .TIMER0_PRIO_HIGH,
  .TIMER1_PRIO_HIGH, .REQ_VALID, .REQ_VECTOR);
`default_nettype wire

// >>> verilog/dtc_pin_if.sv
/*
  Carrier for one synchronised input pin: its sampled level and a one-cycle
  falling-edge pulse. Assumes both ends run on the same clock.
*/
`default_nettype none
interface dtc_pin_if;
  logic level;
  logic fall;
  modport drive (output level, output fall);
  modport use_pin (input level, input fall);
endinterface : dtc_pin_if
`default_nettype wire

// >>> verilog/dtc_pin_sync.sv
/*
  Two-flop synchroniser for one asynchronous pin, plus a third sample used
  only for falling-edge detection. Assumes the pin may change at any time.
*/
`default_nettype none
module dtc_pin_sync (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  pin,
  dtc_pin_if.drive   pin_o
);
  import dtc_pkg::*;

  typedef struct packed {
    logic meta;
    logic sample;
    logic prev;
  } dtc_sync_t;

  dtc_sync_t state;
  dtc_sync_t next_state;

  always_comb begin
    next_state        = state;
    next_state.meta   = pin;
    next_state.sample = state.meta;
    next_state.prev   = state.sample;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '{meta: 1'b1, sample: 1'b1, prev: 1'b1};
    end else begin
      state <= next_state;
    end
  end

  // Falling edge: previous sample high, current sample low.
  assign pin_o.level = state.sample;
  assign pin_o.fall  = state.prev & ~state.sample;
endmodule : dtc_pin_sync
`default_nettype wire

// >>> verilog/dtc_pkg.sv
/*
  Constants for the dual timer/counter: register offsets, field positions,
  reset values, mode codes, divider counts and interrupt vectors.
  Assumes an 8-bit register port with byte addresses.
*/
`default_nettype none
package dtc_pkg;
  // Register offsets, one byte each.
  localparam logic [7:0] OFS_CONTROL_FLAGS = 8'h88;
  localparam logic [7:0] OFS_MODE_SELECT   = 8'h89;
  localparam logic [7:0] OFS_T0_LOW        = 8'h8a;
  localparam logic [7:0] OFS_T1_LOW        = 8'h8b;
  localparam logic [7:0] OFS_T0_HIGH       = 8'h8c;
  localparam logic [7:0] OFS_T1_HIGH       = 8'h8d;
  localparam logic [7:0] OFS_DIVIDER_CTRL  = 8'h8e;
  localparam logic [7:0] OFS_INT_ENABLE    = 8'ha8;
  localparam logic [7:0] OFS_INT_PRIORITY  = 8'hb8;
  localparam logic [7:0] OFS_EVENT_STATUS  = 8'hf0;
  localparam logic [7:0] OFS_EVENT_MASK    = 8'hf1;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // Field positions in timer_control_flags.
  localparam int BIT_T1_FLAG = 7;
  localparam int BIT_T1_RUN  = 6;
  localparam int BIT_T0_FLAG = 5;
  localparam int BIT_T0_RUN  = 4;
  // Field positions in timer_mode_select; timer 1 fields sit four bits higher.
  localparam int BIT_GATE    = 3;
  localparam int BIT_CT      = 2;
  localparam int POS_MODE    = 0;
  localparam int T1_SHIFT    = 4;
  // Field positions in clock_divider_control.
  localparam int BIT_T1_DIV  = 4;
  localparam int BIT_T0_DIV  = 3;
  // Field positions in interrupt_enable and interrupt_priority.
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_T1_INT    = 3;
  localparam int BIT_T0_INT    = 1;
  localparam logic [7:0] IE_WRITABLE = 8'hbf;
  localparam logic [7:0] IP_WRITABLE = 8'h3f;
  // Event status bits.
  localparam int EVT_T0 = 0;
  localparam int EVT_T1 = 1;
  localparam logic [7:0] EVT_WRITABLE = 8'h03;

  // Mode field codes.
  localparam logic [1:0] MODE_13BIT  = 2'h0;
  localparam logic [1:0] MODE_16BIT  = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // System clock divisions for the internal tick.
  localparam int DIV_FAST = 4;
  localparam int DIV_SLOW = 12;

  // Interrupt vectors and natural priorities (lower number is served first).
  localparam logic [7:0] VEC_T0  = 8'h0b;
  localparam logic [7:0] VEC_T1  = 8'h1b;
  localparam int         NAT_T0  = 2;
  localparam int         NAT_T1  = 4;
endpackage : dtc_pkg
`default_nettype wire

// >>> verilog/dtc_prescale.sv
/*
  Free-running divider that pulses a tick once every DIV_FAST or DIV_SLOW
  system clocks. Assumes fast_sel comes from a register on the same clock.
*/
`default_nettype none
module dtc_prescale #(
  parameter int CNT_W = 4
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic fast_sel,
  output logic      tick
);
  import dtc_pkg::*;

  localparam logic [CNT_W-1:0] LAST_FAST = CNT_W'(DIV_FAST - 1);
  localparam logic [CNT_W-1:0] LAST_SLOW = CNT_W'(DIV_SLOW - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } dtc_div_t;

  dtc_div_t         state;
  dtc_div_t         next_state;
  logic [CNT_W-1:0] last;

  // A change of division mid-period is safe: the compare is >= so the
  // counter never runs past the new limit.
  always_comb begin
    last       = fast_sel ? LAST_FAST : LAST_SLOW;
    tick       = (state.cnt >= last);
    next_state = state;
    if (tick) begin
      next_state.cnt = '0;
    end else begin
      next_state.cnt = state.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '{cnt: '0};
    end else begin
      state <= next_state;
    end
  end
endmodule : dtc_prescale
`default_nettype wire

// >>> verilog/dtc_timer_top.sv
/*
  Two 8+8-bit timer/counters with four modes, a byte register port, timer
  interrupt requests with priority and vector, and a status/mask interrupt.
  Assumes the core pulses VECTOR_ACK0/1 for one cycle when it vectors to a
  timer's routine, and that pins arrive asynchronously.

// Notes on behaviour
// - Internal tick is system clock divided by 4 when divider bit is 1, else 12.
// - Counter mode increments once per falling pin edge, never on rising edges.
// - Count and gate pins are sampled every clock; edges come from samples.
// - Two-bit mode field: 0 13-bit, 1 16-bit, 2 auto-reload, 3 split or hold.
// - Mode 0 counts high byte over low five bits; upper low bits ignored.
// - Mode 0 sets overflow flag when 13-bit count wraps to zero.
// - Mode 1 cascades both bytes as 16 bits; wrap sets overflow flag.
// - Mode 2 counts low byte; overflow sets flag and reloads from high byte.
// - Mode 3 splits timer 0 in two bytes; timer 1 in mode 3 holds.
// - Split high byte runs on timer 1 run bit and sets timer 1 flag.
// - With gating set, count only while gate pin high and run set.
// - Counter/timer select 1 counts pin edges, 0 counts divided clock.
// - Run bit 1 counts; 0 stops and holds the value.
// - Overflow flag clears when the core signals vectoring to that routine.
// - Priority bit 1 places the timer interrupt in the high level.
// - Software writes to interrupt bits act exactly like hardware changes.
// - Timer 0 vector 0x0B natural priority 2; timer 1 vector 0x1B priority 4.
*/
// The plain strobed port was left to the implementer.
`default_nettype none
module dtc_timer_top (
  input  wire logic  CLK,
  input  wire logic  RESET,
  input  wire logic  [7:0] ADDR,
  input  wire logic  [7:0] WDATA,
  input  wire logic  WR,
  input  wire logic  RD,
  output logic       [7:0] RDATA,
  input  wire logic  TIMER0_COUNT_PIN,
  input  wire logic  TIMER1_COUNT_PIN,
  input  wire logic  TIMER0_GATE_PIN,
  input  wire logic  TIMER1_GATE_PIN,
  input  wire logic  VECTOR_ACK0,
  input  wire logic  VECTOR_ACK1,
  output logic       TIMER0_REQ,
  output logic       TIMER1_REQ,
  output logic       TIMER0_PRIO_HIGH,
  output logic       TIMER1_PRIO_HIGH,
  output logic       REQ_VALID,
  output logic       REQ_HIGH,
  output logic       [7:0] REQ_VECTOR,
  output logic       IRQ
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [7:0] control_flags;
    logic [7:0] mode_select;
    logic [7:0] t0_low;
    logic [7:0] t1_low;
    logic [7:0] t0_high;
    logic [7:0] t1_high;
    logic [7:0] divider_ctrl;
    logic [7:0] int_enable;
    logic [7:0] int_priority;
    logic [7:0] event_status;
    logic [7:0] event_mask;
    logic [7:0] rdata;
    logic [7:0] req_vector;
    logic       req_valid;
    logic       req_high;
    logic       t0_req;
    logic       t1_req;
  } dtc_state_t;

  dtc_state_t state;
  dtc_state_t next_state;

  dtc_pin_if cnt0_if ();
  dtc_pin_if cnt1_if ();
  dtc_pin_if timer0_gate_pin_if ();
  dtc_pin_if timer1_gate_pin_if ();

  logic tick0;
  logic tick1;

  dtc_pin_sync u_cnt0 (
    .clk   (CLK),
    .reset (RESET),
    .pin   (TIMER0_COUNT_PIN),
    .pin_o (cnt0_if)
  );

  dtc_pin_sync u_cnt1 (
    .clk   (CLK),
    .reset (RESET),
    .pin   (TIMER1_COUNT_PIN),
    .pin_o (cnt1_if)
  );

  dtc_pin_sync u_timer0_gate_pin (
    .clk   (CLK),
    .reset (RESET),
    .pin   (TIMER0_GATE_PIN),
    .pin_o (timer0_gate_pin_if)
  );

  dtc_pin_sync u_timer1_gate_pin (
    .clk   (CLK),
    .reset (RESET),
    .pin   (TIMER1_GATE_PIN),
    .pin_o (timer1_gate_pin_if)
  );

  // Each timer has its own free-running divider, so the first tick after a
  // run bit is set may come early; internal timing is exact to one tick.
  dtc_prescale #(.CNT_W(4)) u_div0 (
    .clk      (CLK),
    .reset    (RESET),
    .fast_sel (state.divider_ctrl[BIT_T0_DIV]),
    .tick     (tick0)
  );

  dtc_prescale #(.CNT_W(4)) u_div1 (
    .clk      (CLK),
    .reset    (RESET),
    .fast_sel (state.divider_ctrl[BIT_T1_DIV]),
    .tick     (tick1)
  );

  // One count step for a high/low byte pair. Result is {overflow, high, low}.
  function automatic logic [16:0] dtc_step(
    input logic [1:0] mode,
    input logic [7:0] hi,
    input logic [7:0] lo,
    input logic       inc
  );
    logic       ovf;
    logic [7:0] nhi;
    logic [7:0] nlo;
    logic [15:0] both;
    ovf  = 1'b0;
    nhi  = hi;
    nlo  = lo;
    both = {hi, lo} + 16'h0001;
    if (inc) begin
      // All four codes are legal, so the case needs no default.
      unique case (mode)
        MODE_13BIT: begin
          // The upper three low-byte bits are left untouched.
          nlo[4:0] = lo[4:0] + 5'h01;
          if (lo[4:0] == 5'h1f) begin
            nhi = hi + 8'h01;
            ovf = (hi == 8'hff);
          end
        end
        MODE_16BIT: begin
          nhi = both[15:8];
          nlo = both[7:0];
          ovf = ({hi, lo} == 16'hffff);
        end
        MODE_RELOAD: begin
          ovf = (lo == 8'hff);
          nlo = ovf ? hi : lo + 8'h01;
        end
        MODE_SPLIT: begin
          ovf = (lo == 8'hff);
          nlo = lo + 8'h01;
        end
      endcase
    end
    return {ovf, nhi, nlo};
  endfunction : dtc_step

  // Per-cycle values of the count and request logic below.
  logic [1:0]  mode0;
  logic [1:0]  mode1;
  logic        en0;
  logic        en1;
  logic        inc0;
  logic        inc1;
  logic        inc0_high;
  logic        split0;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0]  high0_sum;
  logic        ovf0;
  logic        ovf1;
  logic        req0;
  logic        req1;
  logic        hi0;
  logic        hi1;

  always_comb begin
    next_state = state;

    mode0  = state.mode_select[POS_MODE +: 2];
    mode1  = state.mode_select[POS_MODE + T1_SHIFT +: 2];
    split0 = (mode0 == MODE_SPLIT);

    // Gate and run combine into the count enable of each timer.
    en0 = state.control_flags[BIT_T0_RUN] &
          (~state.mode_select[BIT_GATE] | timer0_gate_pin_if.level);
    en1 = state.control_flags[BIT_T1_RUN] &
          (~state.mode_select[BIT_GATE + T1_SHIFT] | timer1_gate_pin_if.level);

    inc0 = en0 & (state.mode_select[BIT_CT] ? cnt0_if.fall : tick0);
    inc1 = en1 & (state.mode_select[BIT_CT + T1_SHIFT] ? cnt1_if.fall : tick1);
    // Timer 1 in mode 3 holds its count, as if its run bit were clear.
    if (mode1 == MODE_SPLIT) begin
      inc1 = 1'b0;
    end

    // Both timers share one step function; only their arguments differ.
    step0 = dtc_step(mode0, state.t0_high, state.t0_low, inc0);
    step1 = dtc_step(mode1, state.t1_high, state.t1_low, inc1);

    // The split high byte is a pure timer on timer 0's divided clock,
    // enabled by timer 1's run bit alone.
    inc0_high = split0 & state.control_flags[BIT_T1_RUN] & tick0;
    high0_sum = {1'b0, state.t0_high} + 9'h001;

    next_state.t0_low  = step0[7:0];
    next_state.t0_high = split0 ? (inc0_high ? high0_sum[7:0] : state.t0_high) : step0[15:8];
    next_state.t1_low  = step1[7:0];
    next_state.t1_high = step1[15:8];

    ovf0 = step0[16];
    // While timer 0 is split, timer 1's own overflow no longer reaches its flag.
    ovf1 = split0 ? (inc0_high & high0_sum[8]) : step1[16];

    // Register writes: a software write to a count byte wins over counting.
    // Unmapped offsets and the read-only status byte ignore writes.
    if (WR) begin
      unique case (ADDR)
        OFS_CONTROL_FLAGS: next_state.control_flags = WDATA;
        OFS_MODE_SELECT:   next_state.mode_select   = WDATA;
        OFS_T0_LOW:        next_state.t0_low        = WDATA;
        OFS_T1_LOW:        next_state.t1_low        = WDATA;
        OFS_T0_HIGH:       next_state.t0_high       = WDATA;
        OFS_T1_HIGH:       next_state.t1_high       = WDATA;
        OFS_DIVIDER_CTRL:  next_state.divider_ctrl  = WDATA;
        OFS_INT_ENABLE:    next_state.int_enable    = WDATA & IE_WRITABLE;
        OFS_INT_PRIORITY:  next_state.int_priority  = WDATA & IP_WRITABLE;
        OFS_EVENT_MASK:    next_state.event_mask    = WDATA & EVT_WRITABLE;
        default: ;
      endcase
    end

    // Vectoring clears the flag; a same-cycle overflow still sets it.
    if (VECTOR_ACK0) begin
      next_state.control_flags[BIT_T0_FLAG] = 1'b0;
    end
    if (VECTOR_ACK1) begin
      next_state.control_flags[BIT_T1_FLAG] = 1'b0;
    end
    if (ovf0) begin
      next_state.control_flags[BIT_T0_FLAG] = 1'b1;
    end
    if (ovf1) begin
      next_state.control_flags[BIT_T1_FLAG] = 1'b1;
    end

    // Sticky overflow events: a status read clears them, a new event wins.
    if (RD && ADDR == OFS_EVENT_STATUS) begin
      next_state.event_status = 8'h00;
    end
    if (ovf0) begin
      next_state.event_status[EVT_T0] = 1'b1;
    end
    if (ovf1) begin
      next_state.event_status[EVT_T1] = 1'b1;
    end

    // Read data stands in the cycle after the strobe only.
    next_state.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        OFS_CONTROL_FLAGS: next_state.rdata = state.control_flags;
        OFS_MODE_SELECT:   next_state.rdata = state.mode_select;
        OFS_T0_LOW:        next_state.rdata = state.t0_low;
        OFS_T1_LOW:        next_state.rdata = state.t1_low;
        OFS_T0_HIGH:       next_state.rdata = state.t0_high;
        OFS_T1_HIGH:       next_state.rdata = state.t1_high;
        OFS_DIVIDER_CTRL:  next_state.rdata = state.divider_ctrl;
        OFS_INT_ENABLE:    next_state.rdata = state.int_enable;
        OFS_INT_PRIORITY:  next_state.rdata = state.int_priority;
        OFS_EVENT_STATUS:  next_state.rdata = state.event_status;
        OFS_EVENT_MASK:    next_state.rdata = state.event_mask;
        default:           next_state.rdata = 8'h00;
      endcase
    end

    // Requests follow the registered flags, so a software set or clear of a
    // flag or enable raises or cancels a request just as hardware does.
    req0 = state.control_flags[BIT_T0_FLAG] & state.int_enable[BIT_T0_INT] &
           state.int_enable[BIT_GLOBAL_EN];
    req1 = state.control_flags[BIT_T1_FLAG] & state.int_enable[BIT_T1_INT] &
           state.int_enable[BIT_GLOBAL_EN];
    hi0  = state.int_priority[BIT_T0_INT];
    hi1  = state.int_priority[BIT_T1_INT];

    next_state.t0_req    = req0;
    next_state.t1_req    = req1;
    next_state.req_valid = req0 | req1;
    next_state.req_high  = (req0 & hi0) | (req1 & hi1);
    next_state.req_vector = 8'h00;
    // High level first; inside a level the lower natural priority wins.
    if (req0 && (hi0 || !(req1 && hi1)) && (NAT_T0 < NAT_T1 || !req1)) begin
      next_state.req_vector = VEC_T0;
    end else if (req1) begin
      next_state.req_vector = VEC_T1;
    end
    if (req0 && req1 && hi1 && !hi0) begin
      next_state.req_vector = VEC_T1;
    end
  end

  // Count bytes reset to zero although software loads them before use; a
  // known value keeps early reads deterministic.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= '{control_flags: RST_BYTE, mode_select: RST_BYTE, t0_low: RST_BYTE,
                 t1_low: RST_BYTE, t0_high: RST_BYTE, t1_high: RST_BYTE,
                 divider_ctrl: RST_BYTE, int_enable: RST_BYTE, int_priority: RST_BYTE,
                 event_status: RST_BYTE, event_mask: RST_BYTE, rdata: RST_BYTE,
                 req_vector: RST_BYTE, req_valid: 1'b0, req_high: 1'b0,
                 t0_req: 1'b0, t1_req: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  assign RDATA            = state.rdata;
  assign TIMER0_REQ       = state.t0_req;
  assign TIMER1_REQ       = state.t1_req;
  assign TIMER0_PRIO_HIGH = state.int_priority[BIT_T0_INT];
  assign TIMER1_PRIO_HIGH = state.int_priority[BIT_T1_INT];
  assign REQ_VALID        = state.req_valid;
  assign REQ_HIGH         = state.req_high;
  assign REQ_VECTOR       = state.req_vector;
  // Built from registers, so the line drops one cycle after the clearing read.
  assign IRQ              = |(state.event_status & state.event_mask);
endmodule : dtc_timer_top
`default_nettype wire
